// ==== rtl/dar_cfg.svh ====
// Register indices, reset values, field masks and counts of the DMA address register bank
`ifndef DAR_CFG_SVH
`define DAR_CFG_SVH

// Register indices; the byte address is four times the index
`define DAR_IDX_FIR_NEXT_LO   32'h0f00_0034
`define DAR_IDX_FIR_NEXT_HI   32'h0f00_0036
`define DAR_IDX_RAM_BASE_LO   32'h0f00_01e0
`define DAR_IDX_RAM_BASE_HI   32'h0f00_01e2
`define DAR_IDX_RAM_NEXT_LO   32'h0f00_01e4
`define DAR_IDX_RAM_NEXT_HI   32'h0f00_01e6
`define DAR_IDX_CTRL          32'h0f00_01f0

// Reset values of the 16-bit halves, the whole 27-bit address and the control bit
`define DAR_RST_LO            16'hf800
`define DAR_RST_HI            16'h01ff
`define DAR_RST_ADDR          27'h1ff_f800
`define DAR_RST_CTRL          1'b0

// Bits software may write
`define DAR_WM_FIR_NEXT_LO    16'h0fff
`define DAR_WM_FIR_NEXT_HI    16'h0000
`define DAR_WM_RAM_BASE_LO    16'hfffc
`define DAR_WM_RAM_BASE_HI    16'h07ff
`define DAR_WM_RAM_NEXT_LO    16'hfffc
`define DAR_WM_RAM_NEXT_HI    16'h0003

// Bits that read back; all others read zero
`define DAR_RM_FIR_LO         16'hffff
`define DAR_RM_RAM_LO         16'hfffc
`define DAR_RM_HI             16'h07ff

// Field positions
`define DAR_CTRL_EXT_BIT      0
`define DAR_HI_LSB            16

// Buffer geometry and access step
`define DAR_BUF_BYTES         27'h000_0800
`define DAR_MASK_10           27'h000_03ff
`define DAR_MASK_11           27'h000_07ff
`define DAR_MASK_NONE         27'h000_0000
`define DAR_STEP              27'h000_0004

// Bus responses
`define DAR_RESP_OKAY         2'b00
`define DAR_RESP_SLVERR       2'b10

`endif

// ==== rtl/dar_pkg.sv ====
// Types shared by the DMA address register bank
package dar_pkg;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } dar_wr_req_type;

   typedef struct packed {
      logic        pulse;
      logic [26:0] data;
      logic [26:0] mask;
   } dar_sw_wr_type;

endpackage : dar_pkg

// ==== rtl/dar_axil.sv ====
// AXI4-Lite slave front end of the DMA address register bank
`timescale 1ns/1ns
`include "dar_cfg.svh"
module dar_axil (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic [31:0]             awaddr,
   input  wire logic                    awvalid,
   output logic                         awready,
   input  wire logic [31:0]             wdata,
   input  wire logic [3:0]              wstrb,
   input  wire logic                    wvalid,
   output logic                         wready,
   output logic [1:0]                   bresp,
   output logic                         bvalid,
   input  wire logic                    bready,
   input  wire logic [31:0]             araddr,
   input  wire logic                    arvalid,
   output logic                         arready,
   output logic [31:0]                  rdata,
   output logic [1:0]                   rresp,
   output logic                         rvalid,
   input  wire logic                    rready,
   output dar_pkg::dar_wr_req_type      wr_req,
   output logic                         wr_go,
   input  wire logic                    wr_hit,
   output logic [31:0]                  rd_addr,
   input  wire logic [31:0]             rd_data,
   input  wire logic                    rd_hit
);
   logic        aw_full_q;
   logic        w_full_q;
   logic        rd_pend_q;
   logic [31:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic [31:0] araddr_q;

   wire aw_take = awvalid && awready;
   wire w_take  = wvalid && wready;
   wire ar_take = arvalid && arready;
   wire do_wr   = aw_full_q && w_full_q && !bvalid;
   wire b_done  = bvalid && bready;
   wire r_done  = rvalid && rready;
   wire aw_full_d = !do_wr && (aw_full_q || aw_take);
   wire w_full_d  = !do_wr && (w_full_q || w_take);

   assign wr_go   = do_wr;
   assign wr_req  = '{addr: awaddr_q, data: wdata_q, strb: wstrb_q};
   assign rd_addr = araddr_q;

   // Write path: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         awready   <= 1'b0;
         wready    <= 1'b0;
         bvalid    <= 1'b0;
         bresp     <= `DAR_RESP_OKAY;
         awaddr_q  <= 32'h0000_0000;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q  <= w_full_d;
         awready   <= !aw_full_d;
         wready    <= !w_full_d;
         if (aw_take) begin
            awaddr_q <= awaddr;
         end
         if (w_take) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (do_wr) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? `DAR_RESP_OKAY : `DAR_RESP_SLVERR;
         end else if (b_done) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Read path: data answered on the edge after the one that takes the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready   <= 1'b0;
         rd_pend_q <= 1'b0;
         rvalid    <= 1'b0;
         rdata     <= 32'h0000_0000;
         rresp     <= `DAR_RESP_OKAY;
         araddr_q  <= 32'h0000_0000;
      end else begin
         if (ar_take) begin
            araddr_q  <= araddr;
            rd_pend_q <= 1'b1;
            arready   <= 1'b0;
         end else if (rd_pend_q) begin
            rd_pend_q <= 1'b0;
            rvalid    <= 1'b1;
            rdata     <= rd_data;
            rresp     <= rd_hit ? `DAR_RESP_OKAY : `DAR_RESP_SLVERR;
         end else if (r_done) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end else if (!rvalid) begin
            arready <= 1'b1;
         end
      end
   end
endmodule : dar_axil

// ==== rtl/dar_chan.sv ====
// Next-address counter of one DMA channel
`timescale 1ns/1ns
`include "dar_cfg.svh"
module dar_chan #(
   parameter int          AW        = 27,
   parameter logic [26:0] RST_VALUE = `DAR_RST_ADDR
) (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic [AW-1:0]           base,
   input  wire logic [AW-1:0]           region_mask,
   input  wire logic                    wrap_en,
   input  wire logic                    start,
   input  wire logic                    advance,
   input  wire dar_pkg::dar_sw_wr_type  sw_wr,
   output logic [AW-1:0]                next_q
);
   wire [AW-1:0] buf_start = base & ~region_mask;
   wire [AW-1:0] buf_end   = AW'(buf_start + AW'(`DAR_BUF_BYTES));
   wire [AW-1:0] stepped   = AW'(next_q + AW'(`DAR_STEP));
   wire          at_end    = wrap_en && (stepped == buf_end);
   wire [AW-1:0] advanced  = at_end ? buf_start : stepped;
   wire [AW-1:0] sw_value  = (next_q & ~AW'(sw_wr.mask)) | (AW'(sw_wr.data) & AW'(sw_wr.mask));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         next_q <= AW'(RST_VALUE);
      end else if (start) begin
         next_q <= base; // R8
      end else if (advance) begin
         next_q <= advanced; // R8 R6 R7
      end else if (sw_wr.pulse) begin
         next_q <= sw_value;
      end
   end
endmodule : dar_chan

// ==== rtl/dar_top.sv ====
// DMA address register bank for the infrared channel and the RAM side of I/O-to-RAM transfers
// Summary of operation
// R1: Infrared next address, 27 bits, shown over low bits 15:0 and high bits 10:0.
// R2: Software writes zero to every reserved bit of these registers.
// R3: Reserved bits always read back as zero, whatever was written.
// R4: RAM base address held in low bits 15:2 and high 10:0; word aligned.
// R5: RAM next address shown in low bits 15:2 and high 10:0; bits 1:0 zero.
// R6: Extended-buffer clear: infrared buffer 2 KB from base with low 10 bits cleared.
// R7: Extended-buffer set: infrared buffer 2 KB from base with low 11 bits cleared.
// R8: Next address loads from base at start, then steps per access within buffer; the RAM next address steps with no buffer wrap.
`timescale 1ns/1ns
`include "dar_cfg.svh"
module dar_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [26:0] fir_base_addr,
   input  wire logic        fir_start,
   input  wire logic        fir_advance,
   input  wire logic        ram_start,
   input  wire logic        ram_advance,
   output logic [26:0]      infrared_next_addr,
   output logic [26:0]      ram_next_addr,
   output logic [26:0]      ram_base_addr,
   output logic             infrared_extended_buffer
);
   dar_pkg::dar_wr_req_type wr_req;
   dar_pkg::dar_sw_wr_type  fir_sw;
   dar_pkg::dar_sw_wr_type  ram_sw;
   logic                    wr_go;
   logic [31:0]             rd_addr;
   logic [31:0]             rd_data;
   logic                    rd_hit;
   logic                    wr_hit;
   logic [15:0]             ram_base_lo_q;
   logic [15:0]             ram_base_hi_q;

   // Byte addresses from register indices
   localparam logic [31:0] A_FIR_LO  = `DAR_IDX_FIR_NEXT_LO << 2;
   localparam logic [31:0] A_FIR_HI  = `DAR_IDX_FIR_NEXT_HI << 2;
   localparam logic [31:0] A_RAMB_LO = `DAR_IDX_RAM_BASE_LO << 2;
   localparam logic [31:0] A_RAMB_HI = `DAR_IDX_RAM_BASE_HI << 2;
   localparam logic [31:0] A_RAMN_LO = `DAR_IDX_RAM_NEXT_LO << 2;
   localparam logic [31:0] A_RAMN_HI = `DAR_IDX_RAM_NEXT_HI << 2;
   localparam logic [31:0] A_CTRL    = `DAR_IDX_CTRL << 2;

   dar_axil u_axil (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (s_axi_awaddr),
      .awvalid (s_axi_awvalid),
      .awready (s_axi_awready),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .wvalid  (s_axi_wvalid),
      .wready  (s_axi_wready),
      .bresp   (s_axi_bresp),
      .bvalid  (s_axi_bvalid),
      .bready  (s_axi_bready),
      .araddr  (s_axi_araddr),
      .arvalid (s_axi_arvalid),
      .arready (s_axi_arready),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rvalid  (s_axi_rvalid),
      .rready  (s_axi_rready),
      .wr_req  (wr_req),
      .wr_go   (wr_go),
      .wr_hit  (wr_hit),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_hit  (rd_hit)
   );

   // Write decode
   wire w_fir_lo  = wr_req.addr == A_FIR_LO;
   wire w_fir_hi  = wr_req.addr == A_FIR_HI;
   wire w_ramb_lo = wr_req.addr == A_RAMB_LO;
   wire w_ramb_hi = wr_req.addr == A_RAMB_HI;
   wire w_ramn_lo = wr_req.addr == A_RAMN_LO;
   wire w_ramn_hi = wr_req.addr == A_RAMN_HI;
   wire w_ctrl    = wr_req.addr == A_CTRL;
   assign wr_hit  = w_fir_lo | w_fir_hi | w_ramb_lo | w_ramb_hi | w_ramn_lo | w_ramn_hi | w_ctrl;

   // Byte lanes of the 16-bit halves
   wire [15:0] lane_mask = {{8{wr_req.strb[1]}}, {8{wr_req.strb[0]}}};
   wire [15:0] wd16      = wr_req.data[15:0];
   wire        go_ramb_lo = wr_go && w_ramb_lo;
   wire        go_ramb_hi = wr_go && w_ramb_hi;
   wire        go_ctrl    = wr_go && w_ctrl && wr_req.strb[0];

   // Reserved bits never stored, so they cannot read back
   wire [15:0] ramb_lo_m = lane_mask & `DAR_WM_RAM_BASE_LO; // R3 R4
   wire [15:0] ramb_hi_m = lane_mask & `DAR_WM_RAM_BASE_HI; // R3 R4
   wire [15:0] ramb_lo_d = (ram_base_lo_q & ~ramb_lo_m) | (wd16 & ramb_lo_m);
   wire [15:0] ramb_hi_d = (ram_base_hi_q & ~ramb_hi_m) | (wd16 & ramb_hi_m);
   // Output copy follows the stored halves, new data only on a write to them
   wire [15:0] ramb_lo_n = go_ramb_lo ? ramb_lo_d : ram_base_lo_q; // R4
   wire [15:0] ramb_hi_n = go_ramb_hi ? ramb_hi_d : ram_base_hi_q; // R4

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ram_base_lo_q <= `DAR_RST_LO;
         ram_base_hi_q <= `DAR_RST_HI;
      end else begin
         if (go_ramb_lo) begin
            ram_base_lo_q <= ramb_lo_d; // R4
         end
         if (go_ramb_hi) begin
            ram_base_hi_q <= ramb_hi_d; // R4
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         infrared_extended_buffer <= `DAR_RST_CTRL;
         ram_base_addr            <= `DAR_RST_ADDR;
      end else begin
         if (go_ctrl) begin
            infrared_extended_buffer <= wr_req.data[`DAR_CTRL_EXT_BIT];
         end
         ram_base_addr <= {ramb_hi_n[10:0], ramb_lo_n}; // R4
      end
   end

   // Software writes into the next-address counters, split into 27-bit masks
   wire [15:0] fir_lo_m = lane_mask & `DAR_WM_FIR_NEXT_LO;
   wire [15:0] fir_hi_m = lane_mask & `DAR_WM_FIR_NEXT_HI;
   wire [15:0] ram_lo_m = lane_mask & `DAR_WM_RAM_NEXT_LO; // R5
   wire [15:0] ram_hi_m = lane_mask & `DAR_WM_RAM_NEXT_HI;
   wire [26:0] lo_data  = {11'h000, wd16};
   wire [26:0] hi_data  = {wd16[10:0], 16'h0000};

   assign fir_sw.pulse = wr_go && (w_fir_lo || w_fir_hi);
   assign fir_sw.data  = w_fir_hi ? hi_data : lo_data;
   assign fir_sw.mask  = w_fir_hi ? {fir_hi_m[10:0], 16'h0000} : {11'h000, fir_lo_m};
   assign ram_sw.pulse = wr_go && (w_ramn_lo || w_ramn_hi);
   assign ram_sw.data  = w_ramn_hi ? hi_data : lo_data;
   assign ram_sw.mask  = w_ramn_hi ? {ram_hi_m[10:0], 16'h0000} : {11'h000, ram_lo_m};

   // Infrared buffer region follows the extended-buffer bit
   wire [26:0] fir_region = infrared_extended_buffer ? `DAR_MASK_11 : `DAR_MASK_10; // R6 R7

   dar_chan #(
      .AW        (27),
      .RST_VALUE (`DAR_RST_ADDR)
   ) u_fir_chan (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .base        (fir_base_addr),
      .region_mask (fir_region),
      .wrap_en     (1'b1),
      .start       (fir_start),
      .advance     (fir_advance),
      .sw_wr       (fir_sw),
      .next_q      (infrared_next_addr)
   );

   dar_chan #(
      .AW        (27),
      .RST_VALUE (`DAR_RST_ADDR)
   ) u_ram_chan (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .base        (ram_base_addr),
      .region_mask (`DAR_MASK_NONE),
      .wrap_en     (1'b0),
      .start       (ram_start),
      .advance     (ram_advance),
      .sw_wr       (ram_sw),
      .next_q      (ram_next_addr)
   );

   // Read decode and data selection
   wire r_fir_lo  = rd_addr == A_FIR_LO;
   wire r_fir_hi  = rd_addr == A_FIR_HI;
   wire r_ramb_lo = rd_addr == A_RAMB_LO;
   wire r_ramb_hi = rd_addr == A_RAMB_HI;
   wire r_ramn_lo = rd_addr == A_RAMN_LO;
   wire r_ramn_hi = rd_addr == A_RAMN_HI;
   wire r_ctrl    = rd_addr == A_CTRL;
   assign rd_hit  = r_fir_lo | r_fir_hi | r_ramb_lo | r_ramb_hi | r_ramn_lo | r_ramn_hi | r_ctrl;

   wire [15:0] v_fir_lo  = infrared_next_addr[15:0] & `DAR_RM_FIR_LO; // R1
   wire [15:0] v_fir_hi  = 16'(infrared_next_addr[26:`DAR_HI_LSB]) & `DAR_RM_HI; // R1 R3
   wire [15:0] v_ramb_lo = ram_base_lo_q & `DAR_RM_RAM_LO; // R3 R4
   wire [15:0] v_ramb_hi = ram_base_hi_q & `DAR_RM_HI; // R3
   wire [15:0] v_ramn_lo = ram_next_addr[15:0] & `DAR_RM_RAM_LO; // R5 R3
   wire [15:0] v_ramn_hi = 16'(ram_next_addr[26:`DAR_HI_LSB]) & `DAR_RM_HI; // R5 R3

   assign rd_data = ({32{r_fir_lo}}  & {16'h0000, v_fir_lo})
                  | ({32{r_fir_hi}}  & {16'h0000, v_fir_hi})
                  | ({32{r_ramb_lo}} & {16'h0000, v_ramb_lo})
                  | ({32{r_ramb_hi}} & {16'h0000, v_ramb_hi})
                  | ({32{r_ramn_lo}} & {16'h0000, v_ramn_lo})
                  | ({32{r_ramn_hi}} & {16'h0000, v_ramn_hi})
                  | ({32{r_ctrl}}    & {31'h0000_0000, infrared_extended_buffer});
endmodule : dar_top

// ==== bench/dar_properties.sv ====
// Concurrent checks on the ports of the DMA address register bank
`timescale 1ns/1ns
`include "dar_cfg.svh"
module dar_properties (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [31:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_bvalid,
   input wire logic [26:0] fir_base_addr,
   input wire logic        fir_start,
   input wire logic        fir_advance,
   input wire logic        ram_start,
   input wire logic        ram_advance,
   input wire logic [26:0] infrared_next_addr,
   input wire logic [26:0] ram_next_addr,
   input wire logic [26:0] ram_base_addr,
   input wire logic        infrared_extended_buffer
);
   logic [26:0] fir_bstart;
   logic [26:0] fir_step;
   logic        quiet;
   // Buffer start and the plain next step of the infrared channel
   assign fir_bstart = fir_base_addr & ~(infrared_extended_buffer ? `DAR_MASK_11 : `DAR_MASK_10);
   assign fir_step   = infrared_next_addr + `DAR_STEP;
   assign quiet      = !(fir_start || fir_advance || ram_start || ram_advance);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Read taken with no DMA strobe, up to the cycle of its answer
   sequence s_rd(logic [31:0] a);
      s_axi_arvalid && s_axi_arready && s_axi_araddr == a && quiet ##1 quiet ##1 1'b1;
   endsequence
   AST_FIR_RD_LO:
      assert property (s_rd(`DAR_IDX_FIR_NEXT_LO << 2) |->
         s_axi_rvalid && s_axi_rdata == {16'h0000, infrared_next_addr[15:0]})
      else $error("infrared low readback differs");
   AST_FIR_RD_HI:
      assert property (s_rd(`DAR_IDX_FIR_NEXT_HI << 2) |->
         s_axi_rvalid && s_axi_rdata == {16'h0000, 5'h00, infrared_next_addr[26:16]})
      else $error("infrared high readback differs");
   AST_RAM_RD_LO:
      assert property (s_rd(`DAR_IDX_RAM_NEXT_LO << 2) |->
         s_axi_rvalid && s_axi_rdata == {16'h0000, ram_next_addr[15:2], 2'h0})
      else $error("ram next low readback differs");
   AST_RD_RSV:
      assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   AST_BASE_ALIGN:
      assert property (ram_base_addr[1:0] == 2'h0)
      else $error("ram base not word aligned");
   AST_BASE_CHG:
      assert property (!$stable(ram_base_addr) |-> $rose(s_axi_bvalid))
      else $error("ram base changed without a write");
   AST_FIR_START:
      assert property (fir_start |=> infrared_next_addr == $past(fir_base_addr))
      else $error("infrared start did not load base");
   AST_FIR_ADV:
      assert property (fir_advance && !fir_start |=> infrared_next_addr ==
         (($past(fir_step) == $past(fir_bstart) + `DAR_BUF_BYTES) ? $past(fir_bstart) : $past(fir_step)))
      else $error("infrared step or wrap wrong");
   AST_RAM_START:
      assert property (ram_start |=> ram_next_addr == $past(ram_base_addr))
      else $error("ram start did not load base");
   AST_RAM_ADV:
      assert property (ram_advance && !ram_start |=> ram_next_addr == $past(ram_next_addr) + `DAR_STEP)
      else $error("ram step wrong");
endmodule : dar_properties

bind dar_top dar_properties dar_properties_i (
   .aclk                     (aclk),
   .aresetn                  (aresetn),
   .s_axi_araddr             (s_axi_araddr),
   .s_axi_arvalid            (s_axi_arvalid),
   .s_axi_arready            (s_axi_arready),
   .s_axi_rdata              (s_axi_rdata),
   .s_axi_rvalid             (s_axi_rvalid),
   .s_axi_bvalid             (s_axi_bvalid),
   .fir_base_addr            (fir_base_addr),
   .fir_start                (fir_start),
   .fir_advance              (fir_advance),
   .ram_start                (ram_start),
   .ram_advance              (ram_advance),
   .infrared_next_addr       (infrared_next_addr),
   .ram_next_addr            (ram_next_addr),
   .ram_base_addr            (ram_base_addr),
   .infrared_extended_buffer (infrared_extended_buffer)
);

// ==== bench/tb_top.sv ====
// Self-checking testbench of the DMA address register bank
`timescale 1ns/1ns
`include "dar_cfg.svh"
module tb_top;
   typedef struct packed {
      logic [31:0] addr;
      logic        wr;
      logic [31:0] wdata;
      logic [31:0] rexp;
   } dar_row_type;
   localparam logic [31:0] a_fl = `DAR_IDX_FIR_NEXT_LO << 2;
   localparam logic [31:0] a_fh = `DAR_IDX_FIR_NEXT_HI << 2;
   localparam logic [31:0] a_bl = `DAR_IDX_RAM_BASE_LO << 2;
   localparam logic [31:0] a_bh = `DAR_IDX_RAM_BASE_HI << 2;
   localparam logic [31:0] a_nl = `DAR_IDX_RAM_NEXT_LO << 2;
   localparam logic [31:0] a_nh = `DAR_IDX_RAM_NEXT_HI << 2;
   localparam logic [31:0] a_ct = `DAR_IDX_CTRL << 2;
   localparam dar_row_type rows [14] = '{
      '{a_fl, 1'b0, 32'h0000_0000, 32'h0000_f800}, '{a_fh, 1'b0, 32'h0000_0000, 32'h0000_01ff},
      '{a_bl, 1'b0, 32'h0000_0000, 32'h0000_f800}, '{a_bh, 1'b0, 32'h0000_0000, 32'h0000_01ff},
      '{a_nl, 1'b0, 32'h0000_0000, 32'h0000_f800}, '{a_nh, 1'b0, 32'h0000_0000, 32'h0000_01ff},
      '{a_ct, 1'b0, 32'h0000_0000, 32'h0000_0000}, '{a_fl, 1'b1, 32'hffff_5555, 32'h0000_f555},
      '{a_fh, 1'b1, 32'h0000_ffff, 32'h0000_01ff}, '{a_bl, 1'b1, 32'h0000_ffff, 32'h0000_fffc},
      '{a_bh, 1'b1, 32'h0000_ffff, 32'h0000_07ff}, '{a_nl, 1'b1, 32'h0000_1237, 32'h0000_1234},
      '{a_nh, 1'b1, 32'h0000_0000, 32'h0000_01fc}, '{a_ct, 1'b1, 32'h0000_0001, 32'h0000_0001}};
   logic        aclk          = 1'b0;
   logic        aresetn       = 1'b0;
   logic [31:0] s_axi_awaddr  = 32'h0000_0000;
   logic        s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata   = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb   = 4'hf;
   logic        s_axi_wvalid  = 1'b0;
   logic        s_axi_bready  = 1'b0;
   logic [31:0] s_axi_araddr  = 32'h0000_0000;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready  = 1'b0;
   logic [26:0] fir_base_addr = 27'h000_0000;
   logic        fir_start     = 1'b0;
   logic        fir_advance   = 1'b0;
   logic        ram_start     = 1'b0;
   logic        ram_advance   = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        infrared_extended_buffer;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] s_axi_rdata, rd;
   logic [26:0] infrared_next_addr, ram_next_addr, ram_base_addr;
   int          num_errors    = 0;
   int          n_checks      = 0;

   dar_top dar_top_i (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fir_base_addr(fir_base_addr),
      .fir_start(fir_start), .fir_advance(fir_advance), .ram_start(ram_start),
      .ram_advance(ram_advance), .infrared_next_addr(infrared_next_addr),
      .ram_next_addr(ram_next_addr), .ram_base_addr(ram_base_addr),
      .infrared_extended_buffer(infrared_extended_buffer));

   always #5 aclk = ~aclk;

   task automatic test_done();
      $display("errors %0d checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask : chk

   task automatic step(inout int n);
      @(posedge aclk);
      n++;
      if (n > 100) begin
         num_errors++;
         test_done();
      end
   endtask : step

   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      int   n  = 0;
      logic aw = 1'b0;
      logic w  = 1'b0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!(aw && w)) begin
         step(n);
         if (s_axi_awvalid && s_axi_awready) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do step(n); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      int n = 0;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do step(n); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do step(n); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_rd

   task automatic dma(input logic fs, input logic fa, input logic rs, input logic ra);
      @(posedge aclk);
      {fir_start, fir_advance, ram_start, ram_advance} <= {fs, fa, rs, ra};
      @(posedge aclk);
      {fir_start, fir_advance, ram_start, ram_advance} <= 4'h0;
      #1;
   endtask : dma

   task automatic reset_chk();
      chk("fir_next", `DAR_RST_ADDR, infrared_next_addr);
      chk("ram_next", `DAR_RST_ADDR, ram_next_addr);
      chk("ram_base", `DAR_RST_ADDR, ram_base_addr);
      chk("ext", 32'h0000_0000, infrared_extended_buffer);
   endtask : reset_chk

   initial begin
      @(posedge aclk);
      #1;
      reset_chk();
      @(posedge aclk) aresetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            axi_wr(rows[i].addr, rows[i].wdata, rsp);
            chk("bresp", `DAR_RESP_OKAY, rsp);
         end
         axi_rd(rows[i].addr, rd, rsp);
         chk("rdata", rows[i].rexp, rd);
         chk("rresp", `DAR_RESP_OKAY, rsp);
      end
      chk("ram_base", 32'h07ff_fffc, ram_base_addr);
      chk("fir_next", 32'h01ff_f555, infrared_next_addr);
      axi_wr(32'h3c00_00e0, 32'h0000_ffff, rsp);
      chk("bresp", `DAR_RESP_SLVERR, rsp);
      axi_rd(32'h3c00_00e0, rd, rsp);
      chk("rdata", 32'h0000_0000, rd);
      chk("rresp", `DAR_RESP_SLVERR, rsp);
      dma(1'b0, 1'b0, 1'b1, 1'b0);
      chk("ram_next", 32'h07ff_fffc, ram_next_addr);
      dma(1'b0, 1'b0, 1'b0, 1'b1);
      chk("ram_next", 32'h0000_0000, ram_next_addr);
      axi_rd(a_nh, rd, rsp);
      chk("rdata", 32'h0000_0000, rd);
      @(posedge aclk) fir_base_addr <= 27'h012_37f8;
      for (int e = 1; e >= 0; e--) begin
         axi_wr(a_ct, 32'(e), rsp);
         dma(1'b1, 1'b0, 1'b0, 1'b0);
         dma(1'b0, 1'b1, 1'b0, 1'b0);
         dma(1'b0, 1'b1, 1'b0, 1'b0);
         chk("fir_next", e ? 32'h0012_3000 : 32'h0012_3800, infrared_next_addr);
         axi_rd(a_fl, rd, rsp);
         chk("rdata", e ? 32'h0000_3000 : 32'h0000_3800, rd);
      end
      dma(1'b1, 1'b1, 1'b1, 1'b1);
      chk("fir_next", 32'h0012_37f8, infrared_next_addr);
      chk("ram_next", 32'h07ff_fffc, ram_next_addr);
      @(posedge aclk) aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      #1;
      reset_chk();
      @(posedge aclk) aresetn <= 1'b1;
      axi_rd(a_bl, rd, rsp);
      chk("rdata", 32'h0000_f800, rd);
      test_done();
   end
endmodule : tb_top
